/* File: logic/irr_cfg.svh */
// constants for the interrupt request recognizer
`ifndef IRR_CFG_SVH
`define IRR_CFG_SVH

// number of request levels and their width
`define IRR_LVL_W 3
`define IRR_NUM_PINS 7
// level encodings
`define IRR_LVL_NONE 3'h0
`define IRR_LVL_NMI 3'h7
`define IRR_MASK_MAX 3'h7
// reset values
`define IRR_PEND_RST 3'h0
`define IRR_FLAG_RST 1'h0
// samples a pin must be seen asserted before it is valid
`define IRR_HYST_CYCLES 2

`endif

/* File: logic/irr_nmi_detect.sv */
// edge and mask-drop detector for the non-maskable level
`timescale 1ns/10ps
`default_nettype none
`include "irr_cfg.svh"
module irr_nmi_detect
    import irr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // filtered level 7 request and current mask
    input wire logic level_on,
    input wire irr_level_t mask,
    // acknowledge taken at level 7
    input wire logic take,
    output logic nmi_pend
);
    logic level_d_reg;
    irr_level_t mask_d_reg;
    logic nmi_reg;
    logic set_w;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_d_reg <= `IRR_FLAG_RST;
            mask_d_reg <= `IRR_MASK_MAX;
        end else begin
            level_d_reg <= level_on;
            mask_d_reg <= mask;
        end
    end

    // new assertion or mask leaving 7
    assign set_w = (level_on && !level_d_reg)
        || (level_on && mask_d_reg == `IRR_MASK_MAX && mask != `IRR_MASK_MAX);

    // set beats a same-cycle acknowledge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nmi_reg <= `IRR_FLAG_RST;
        end else if (set_w) begin
            nmi_reg <= 1'h1;
        end else if (take) begin
            nmi_reg <= 1'h0;
        end
    end

    assign nmi_pend = nmi_reg;
endmodule : irr_nmi_detect
`default_nettype wire

/* File: logic/irr_pin_filter.sv */
// request pin synchroniser with hysteresis, sampled on falling edges
`timescale 1ns/10ps
`default_nettype none
`include "irr_cfg.svh"
module irr_pin_filter
    import irr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pin and result
    input wire logic pin_n,
    output logic req_valid
);
    logic meta_reg;
    logic sync_reg;
    logic [`IRR_HYST_CYCLES-1:0] hist_reg;

    // two stages before anything looks at the pin
    always_ff @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'h1;
            sync_reg <= 1'h1;
        end else begin
            meta_reg <= pin_n;
            sync_reg <= meta_reg;
        end
    end

    always_ff @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hist_reg <= '0;
        end else begin
            hist_reg <= {hist_reg[`IRR_HYST_CYCLES-2:0], ~sync_reg};
        end
    end

    assign req_valid = &hist_reg;
endmodule : irr_pin_filter
`default_nettype wire

/* File: logic/irr_pkg.sv */
// types shared by the interrupt request recognizer
`include "irr_cfg.svh"
package irr_pkg;
    typedef logic [`IRR_LVL_W-1:0] irr_level_t;
    typedef enum logic {IRR_IDLE, IRR_ACK} irr_ack_state_t;
endpackage : irr_pkg

/* File: logic/irr_top.sv */
// interrupt request recognizer: pin and periodic timer requests to the core
`timescale 1ns/10ps
`default_nettype none
`include "irr_cfg.svh"
module irr_top
    import irr_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // external request pins, active low, index is the level
    input wire logic [`IRR_NUM_PINS:1] REQ_PIN_N,
    // periodic timer, same clock domain
    input wire logic PERIODIC_TIMER_REQ,
    input wire irr_level_t PERIODIC_LEVEL_FIELD,
    output logic TIMER_ACK,
    // core side
    input wire irr_level_t PRIORITY_MASK,
    input wire logic INSTR_BOUNDARY,
    input wire logic IACK_DONE,
    output irr_level_t PENDING_LEVEL,
    output logic PENDING_FROM_TIMER,
    output logic NMI_PENDING,
    // acknowledge cycle
    output logic IACK_CYCLE,
    output irr_level_t IACK_LEVEL,
    output logic IACK_FROM_TIMER
);
    logic [`IRR_NUM_PINS:1] pin_valid;
    logic nmi_pend_w;
    logic nmi_take_w;
    logic tmr_on_w;
    logic [`IRR_NUM_PINS:1] lvl_req_w;
    irr_level_t best_w;
    logic best_timer_w;
    logic start_w;
    irr_ack_state_t state_reg;
    irr_ack_state_t state_next;
    irr_level_t pend_level_reg;
    logic pend_timer_reg;
    logic iack_cycle_reg;
    irr_level_t iack_level_reg;
    logic iack_timer_reg;
    logic timer_ack_reg;

    // one filter per pin, index is level
    genvar g;
    generate
        for (g = 1; g <= `IRR_NUM_PINS; g++) begin : g_pin
            irr_pin_filter u_filt (
                .clk(CLK),
                .rst_n(RST_N),
                .pin_n(REQ_PIN_N[g]),
                .req_valid(pin_valid[g])
            );
        end
    endgenerate

    // level 7 through the edge detector
    irr_nmi_detect u_nmi (
        .clk(CLK),
        .rst_n(RST_N),
        .level_on(pin_valid[`IRR_NUM_PINS]),
        .mask(PRIORITY_MASK),
        .take(nmi_take_w),
        .nmi_pend(nmi_pend_w)
    );

    // zero level field turns the timer off
    assign tmr_on_w = PERIODIC_TIMER_REQ && (PERIODIC_LEVEL_FIELD != `IRR_LVL_NONE);

    // pins and timer merged into one request set
    always_comb begin
        lvl_req_w = {nmi_pend_w, pin_valid[`IRR_NUM_PINS-1:1]};
        if (tmr_on_w) begin
            lvl_req_w[PERIODIC_LEVEL_FIELD] = 1'h1;
        end
    end

    // only levels above the mask count, and level 7 at any mask
    always_comb begin
        best_w = `IRR_LVL_NONE;
        for (int l = 1; l <= `IRR_NUM_PINS; l++) begin
            if (lvl_req_w[l] && (3'(l) > PRIORITY_MASK || 3'(l) == `IRR_LVL_NMI)) begin
                best_w = 3'(l);
            end
        end
    end

    // timer takes a tie at the winning level
    assign best_timer_w = tmr_on_w && (best_w != `IRR_LVL_NONE)
        && (PERIODIC_LEVEL_FIELD == best_w);

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pend_level_reg <= `IRR_PEND_RST;
            pend_timer_reg <= `IRR_FLAG_RST;
        end else begin
            pend_level_reg <= best_w;
            pend_timer_reg <= best_timer_w;
        end
    end

    // service opens only at a boundary
    assign start_w = (state_reg == IRR_IDLE) && INSTR_BOUNDARY
        && (pend_level_reg != `IRR_LVL_NONE);

    // a pin tied with the timer keeps its latch
    assign nmi_take_w = start_w && (pend_level_reg == `IRR_LVL_NMI) && !pend_timer_reg;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            IRR_IDLE: begin
                if (start_w) begin
                    state_next = IRR_ACK;
                end
            end
            IRR_ACK: begin
                if (IACK_DONE) begin
                    state_next = IRR_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= IRR_IDLE;
            iack_cycle_reg <= `IRR_FLAG_RST;
        end else begin
            state_reg <= state_next;
            iack_cycle_reg <= (state_next == IRR_ACK);
        end
    end

    // level held for the whole acknowledge
    // pins are not cleared here, requester drops them
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            iack_level_reg <= `IRR_PEND_RST;
            iack_timer_reg <= `IRR_FLAG_RST;
        end else if (start_w) begin
            iack_level_reg <= pend_level_reg;
            iack_timer_reg <= pend_timer_reg;
        end else if (state_reg == IRR_ACK && IACK_DONE) begin
            iack_level_reg <= `IRR_PEND_RST;
            iack_timer_reg <= `IRR_FLAG_RST;
        end
    end

    // timer has no pin to release, so it gets a pulse
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            timer_ack_reg <= `IRR_FLAG_RST;
        end else begin
            timer_ack_reg <= start_w && pend_timer_reg;
        end
    end

    assign PENDING_LEVEL = pend_level_reg;
    assign PENDING_FROM_TIMER = pend_timer_reg;
    assign NMI_PENDING = nmi_pend_w;
    assign IACK_CYCLE = iack_cycle_reg;
    assign IACK_LEVEL = iack_level_reg;
    assign IACK_FROM_TIMER = iack_timer_reg;
    assign TIMER_ACK = timer_ack_reg;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    property p_mask_blocks;
        (PENDING_LEVEL != `IRR_LVL_NONE && PENDING_LEVEL != `IRR_LVL_NMI)
            |-> (PENDING_LEVEL > $past(PRIORITY_MASK));
    endproperty
    a_mask_blocks: assert property (p_mask_blocks)
        else $error("pending level not above mask");

    property p_nmi_wins;
        nmi_pend_w |=> (PENDING_LEVEL == `IRR_LVL_NMI);
    endproperty
    a_nmi_wins: assert property (p_nmi_wins)
        else $error("level 7 not presented");

    property p_highest;
        (pin_valid[6] && PRIORITY_MASK < 3'h6) |=> (PENDING_LEVEL >= 3'h6);
    endproperty
    a_highest: assert property (p_highest)
        else $error("lower level chosen over level 6");

    property p_timer_tie;
        (tmr_on_w && pin_valid[PERIODIC_LEVEL_FIELD] && PERIODIC_LEVEL_FIELD != `IRR_LVL_NMI
            && PERIODIC_LEVEL_FIELD > PRIORITY_MASK && best_w == PERIODIC_LEVEL_FIELD)
            |=> PENDING_FROM_TIMER;
    endproperty
    a_timer_tie: assert property (p_timer_tie)
        else $error("pin beat timer at equal level");

    property p_timer_off;
        (PERIODIC_LEVEL_FIELD == `IRR_LVL_NONE) |=> !PENDING_FROM_TIMER;
    endproperty
    a_timer_off: assert property (p_timer_off)
        else $error("timer pending at level zero");

    property p_no_stale;
        (best_w == `IRR_LVL_NONE) |=> (PENDING_LEVEL == `IRR_LVL_NONE) [*1] ##0 !PENDING_FROM_TIMER;
    endproperty
    a_no_stale: assert property (p_no_stale)
        else $error("pending level kept with no request");

    property p_follow;
        (best_w > PENDING_LEVEL) |=> (PENDING_LEVEL == $past(best_w));
    endproperty
    a_follow: assert property (p_follow)
        else $error("higher request not taken over");

    property p_boundary;
        $rose(IACK_CYCLE) |-> ($past(INSTR_BOUNDARY) && $past(PENDING_LEVEL) != `IRR_LVL_NONE);
    endproperty
    a_boundary: assert property (p_boundary)
        else $error("acknowledge opened off a boundary");

    property p_iack_level;
        $rose(IACK_CYCLE) |-> (IACK_LEVEL == $past(PENDING_LEVEL)) ##1 (IACK_LEVEL == $past(IACK_LEVEL)
            || !IACK_CYCLE);
    endproperty
    a_iack_level: assert property (p_iack_level)
        else $error("acknowledge level wrong or unstable");

    property p_nmi_edge;
        (!nmi_pend_w && pin_valid[7] && $past(pin_valid[7]) && PRIORITY_MASK == $past(PRIORITY_MASK))
            |=> !nmi_pend_w;
    endproperty
    a_nmi_edge: assert property (p_nmi_edge)
        else $error("held level 7 requested again");

    property p_mask_drop;
        (pin_valid[7] && $past(PRIORITY_MASK) == `IRR_MASK_MAX && PRIORITY_MASK != `IRR_MASK_MAX)
            |=> nmi_pend_w;
    endproperty
    a_mask_drop: assert property (p_mask_drop)
        else $error("mask drop did not raise level 7");

    property p_timer_ack;
        ($rose(IACK_CYCLE) && IACK_FROM_TIMER) |-> TIMER_ACK ##1 !TIMER_ACK;
    endproperty
    a_timer_ack: assert property (p_timer_ack)
        else $error("timer acknowledge pulse missing");

    property p_pin_level;
        (pin_valid[3] && pin_valid[6:4] == 3'h0 && !nmi_pend_w && !tmr_on_w && PRIORITY_MASK < 3'h3)
            |=> (PENDING_LEVEL == 3'h3);
    endproperty
    a_pin_level: assert property (p_pin_level)
        else $error("pin 3 not presented at level 3");

    // filter runs on the falling edge, so this check is clocked there
    property p_hyst;
        @(negedge CLK) pin_valid[2] |-> (!$past(REQ_PIN_N[2], 3) && !$past(REQ_PIN_N[2], 4));
    endproperty
    a_hyst: assert property (p_hyst)
        else $error("pin valid without two asserted samples");

    property p_full_mask;
        ($past(PRIORITY_MASK) == `IRR_MASK_MAX)
            |-> (PENDING_LEVEL == `IRR_LVL_NONE || PENDING_LEVEL == `IRR_LVL_NMI);
    endproperty
    a_full_mask: assert property (p_full_mask)
        else $error("mask 7 let a lower level through");

    property p_iack_close;
        (IACK_CYCLE && IACK_DONE) |=> (!IACK_CYCLE && IACK_LEVEL == `IRR_LVL_NONE && !IACK_FROM_TIMER);
    endproperty
    a_iack_close: assert property (p_iack_close)
        else $error("acknowledge did not close after done");

    property p_tack_only;
        TIMER_ACK |-> (IACK_CYCLE && IACK_FROM_TIMER);
    endproperty
    a_tack_only: assert property (p_tack_only)
        else $error("timer acknowledged for a pin request");

    c_timer_ack: cover property ($rose(IACK_CYCLE) && IACK_FROM_TIMER);
    c_nmi_ack: cover property ($rose(IACK_CYCLE) && IACK_LEVEL == `IRR_LVL_NMI);
    c_mask_drop: cover property (pin_valid[7] && $past(PRIORITY_MASK) == 3'h7 && PRIORITY_MASK == 3'h0);
    c_preempt: cover property (PENDING_LEVEL == 3'h2 ##1 PENDING_LEVEL == 3'h5);
endmodule : irr_top
`default_nettype wire

/* File: testbench/irr_far_model.sv */
// far side model: external requesters and the periodic timer
`timescale 1ns/10ps
`default_nettype none
module irr_far_model
    import irr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // stimulus from the bench
    input wire logic [7:1] raise,
    input wire logic hold,
    input wire logic timer_raise,
    // acknowledge seen from the device
    input wire logic iack_cycle,
    input wire irr_level_t iack_level,
    input wire logic iack_from_timer,
    input wire logic timer_ack,
    // requests to the device
    output logic [7:1] pin_n,
    output logic timer_req
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_n <= 7'h7F;
        end else begin
            for (int i = 1; i <= 7; i++) begin
                if (raise[i]) begin
                    pin_n[i] <= 1'h0;
                end else if (iack_cycle && !iack_from_timer && iack_level == i[2:0] && !hold) begin
                    pin_n[i] <= 1'h1;
                end
            end
        end
    end

    // timer request dropped once acknowledged
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_req <= 1'h0;
        end else if (timer_raise) begin
            timer_req <= 1'h1;
        end else if (timer_ack) begin
            timer_req <= 1'h0;
        end
    end
endmodule : irr_far_model
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the interrupt request recognizer
`timescale 1ns/10ps
`default_nettype none
module testbench
    import irr_pkg::*;
;
    logic clk, rst_n, hold, timer_raise, tmr_req, bound, done, t_ack, nmi, iack, iack_tmr, pend_tmr;
    logic [7:1] raise, pins_n;
    irr_level_t field, mask, pend, iack_lvl;
    int miscompares = 0;
    int samples_checked = 0;
    logic [8:0] rows [8] = '{9'h041, 9'h1A6, 9'h0D8, 9'h0D3, 9'h1FF, 9'h08A, 9'h104, 9'h168};

    irr_top dut_u (.CLK(clk), .RST_N(rst_n), .REQ_PIN_N(pins_n), .PERIODIC_TIMER_REQ(tmr_req),
        .PERIODIC_LEVEL_FIELD(field), .TIMER_ACK(t_ack), .PRIORITY_MASK(mask), .INSTR_BOUNDARY(bound),
        .IACK_DONE(done), .PENDING_LEVEL(pend), .PENDING_FROM_TIMER(pend_tmr), .NMI_PENDING(nmi),
        .IACK_CYCLE(iack), .IACK_LEVEL(iack_lvl), .IACK_FROM_TIMER(iack_tmr));
    irr_far_model far_u (.clk(clk), .rst_n(rst_n), .raise(raise), .hold(hold), .timer_raise(timer_raise),
        .iack_cycle(iack), .iack_level(iack_lvl), .iack_from_timer(iack_tmr), .timer_ack(t_ack),
        .pin_n(pins_n), .timer_req(tmr_req));

    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic do_reset(input irr_level_t m);
        rst_n <= 1'h0;
        mask <= m;
        tick(6);
        rst_n <= 1'h1;
        tick(1);
    endtask : do_reset

    task automatic pulse_pins(input logic [7:1] p);
        raise <= p;
        tick(1);
        raise <= 7'h00;
    endtask : pulse_pins

    // open an acknowledge and close it after a few cycles
    task automatic do_ack(input irr_level_t lvl, input logic tmr);
        int n;
        chk("idle before boundary", 3'h0, {2'h0, iack});
        bound <= 1'h1;
        tick(1);
        bound <= 1'h0;
        n = 0;
        @(negedge clk);
        while (iack !== 1'h1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        chk("iack level", lvl, iack_lvl);
        chk("iack from timer", {2'h0, tmr}, {2'h0, iack_tmr});
        chk("timer ack", {2'h0, tmr}, {2'h0, t_ack});
        tick(2);
        done <= 1'h1;
        tick(1);
        done <= 1'h0;
        tick(2);
    endtask : do_ack

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #150000;
        miscompares++;
        tally_and_finish();
    end

    initial begin
        rst_n = 1'h0;
        raise = 7'h00;
        hold = 1'h0;
        timer_raise = 1'h0;
        field = 3'h0;
        mask = 3'h0;
        bound = 1'h0;
        done = 1'h0;
        // rows: pin level, mask, expected pending level
        foreach (rows[i]) begin
            do_reset(rows[i][5:3]);
            chk("reset pending", 3'h0, pend);
            pulse_pins(7'h01 << (rows[i][8:6] - 3'h1));
            tick(8);
            @(negedge clk);
            chk("row pending", rows[i][2:0], pend);
        end
        $display("test rows done");
        do_reset(3'h0);
        pulse_pins(7'h12);
        tick(8);
        chk("highest of two", 3'h5, pend);
        do_ack(3'h5, 1'h0);
        tick(6);
        chk("lower after ack", 3'h2, pend);
        $display("test priority done");
        do_reset(3'h0);
        pulse_pins(7'h08);
        timer_raise <= 1'h1;
        tick(1);
        timer_raise <= 1'h0;
        tick(8);
        chk("timer off", 3'h0, {2'h0, pend_tmr});
        field <= 3'h4;
        tick(2);
        chk("timer wins tie", 3'h1, {2'h0, pend_tmr});
        do_ack(3'h4, 1'h1);
        chk("pin left pending", 3'h4, pend);
        chk("pending from pin", 3'h0, {2'h0, pend_tmr});
        field <= 3'h0;
        $display("test timer done");
        hold <= 1'h1;
        do_reset(3'h7);
        pulse_pins(7'h40);
        tick(8);
        chk("nmi under full mask", 3'h1, {2'h0, nmi});
        do_ack(3'h7, 1'h0);
        tick(8);
        chk("no repeat nmi", 3'h0, {2'h0, nmi});
        chk("no repeat pending", 3'h0, pend);
        mask <= 3'h3;
        tick(4);
        chk("nmi on mask drop", 3'h1, {2'h0, nmi});
        $display("test nmi done");
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
